// file: core/slcr_pkg.sv
// Purpose: constants and carriers for the serializer link control registers
// Assumes: 8-bit registers on a plain strobe port, one 100 MHz clock
// Notes: partner identifier default is an arbitrary neutral value
`default_nettype none
package slcr_pkg;
	localparam logic [7:0] SLCR_ADDR_LPRX = 8'h23;
	localparam logic [7:0] SLCR_ADDR_TERM = 8'h24;
	localparam logic [7:0] SLCR_ADDR_HDR = 8'h31;
	localparam logic [7:0] SLCR_ADDR_BCC = 8'h32;
	localparam logic [7:0] SLCR_ADDR_FWD = 8'h33;
	localparam logic [7:0] SLCR_ADDR_CAP = 8'h35;
	localparam logic [7:0] SLCR_ADDR_PID = 8'h37;
	localparam logic [7:0] SLCR_RST_LPRX = 8'h00;
	localparam logic [7:0] SLCR_RST_TERM = 8'h00;
	localparam logic [7:0] SLCR_RST_HDR = 8'h20;
	localparam logic [7:0] SLCR_RST_BCC = 8'h09;
	localparam logic [7:0] SLCR_RST_FWD = 8'h04;
	localparam logic [7:0] SLCR_RST_CAP = 8'h00;
	// arbitrary neutral partner identifier default
	localparam logic [6:0] SLCR_PID_DEFAULT = 7'h2a;
	localparam logic [7:0] SLCR_LPRX_WMASK = 8'h7f;
	localparam int SLCR_HDR_SEL_LSB = 6;
	localparam int SLCR_HDR_CORR_BIT = 5;
	localparam int SLCR_HDR_VCI_BIT = 4;
	localparam int SLCR_BCC_ALL_BIT = 7;
	localparam int SLCR_BCC_MATCH_BIT = 6;
	localparam int SLCR_BCC_ACK_BIT = 5;
	localparam int SLCR_BCC_PAR_BIT = 3;
	localparam int SLCR_FWD_CRC_BIT = 2;
	localparam int SLCR_CAP_FRZ_BIT = 7;
	localparam int SLCR_PID_FRZ_BIT = 0;
	localparam int SLCR_STEP_NS = 100000;
	localparam int SLCR_CLK_NS = 10;
	localparam int SLCR_STEP_CYC = (SLCR_STEP_NS + SLCR_CLK_NS - 1) / SLCR_CLK_NS;
	localparam logic [7:0] SLCR_CRC_BYTES = 8'h08;
	localparam logic [7:0] SLCR_CRC_POS = 8'h09;
	typedef struct packed {
		logic selftest;
		logic multiport;
		logic [3:0] port_num;
	} slcr_cap_s;
	typedef struct packed {
		logic valid;
		slcr_cap_s cap;
		logic [6:0] id;
	} slcr_partner_s;
	typedef struct packed {
		logic [1:0] header_channel_select;
		logic header_view_corrected;
		logic per_channel_header_capture_en;
		logic forward_all;
		logic forward_matched;
		logic auto_ack;
		logic parity_check_en;
		logic control_sequence_crc_en;
		logic [2:0] forward_gpio_lanes;
		logic [3:0] lane_termination_en;
	} slcr_ctrl_s;
endpackage : slcr_pkg
`default_nettype wire

// file: core/slcr_regs.sv
// Purpose: configuration registers of the serializer link control block
// Assumes: software port strobes are on sys_clk; link inputs pass two flops
// Notes: read data stand one cycle after the read strobe
//
// Overview of operation
// R01: lane low-power control is ignored after reset until the start interval ends
// R02: interval field selects (code+1) times 100 us, 000 shortest, 111 800 us
// R03: header view bit 1 shows corrected header, 0 shows raw header
// R04: channel select picks the recorded channel only while capture enable is set
// R05: capture enable records headers per channel for interleaved traffic only
// R06: forward-all bit passes every local I2C transaction to the partner
// R07: matched-forward bit passes transactions only on address decode match
// R08: auto-acknowledge bit acks every write regardless of lock and remote ack
// R09: back-channel parity is checked while enable bit is 1, its reset value
// R10: CRC enable appends CRC over eight control bytes as the ninth byte
// R11: forward GPIO count code 00,01,10,11 means 0,1,2,4 GPIOs
// R12: capability freeze stops automatic loading of partner capability fields
// R13: on back-channel detect capability fields load automatically unless frozen
// R14: software overwriting capabilities must also set the capability freeze
// R15: self-test request bit shows the partner asks for link self-test
// R16: multiport bit reads 0 for single-port, 1 for multi-port partner
// R17: port number field reports partner port this serializer is attached to
// R18: seven-bit partner identifier loads automatically over the back channel
// R19: identifier freeze stops automatic identifier loading, keeping written value
// R20: four writable lane termination enables, reset to zero, debug only
// R21: all fields take defaults on reset; writable reserved bits hold writes
`default_nettype none
module slcr_regs
	import slcr_pkg::*;
#(
	parameter int STEP_CYC = SLCR_STEP_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic link_partner_valid,
	input wire logic [5:0] link_partner_cap,
	input wire logic [6:0] link_partner_id,
	input wire logic hdr_match,
	input wire logic i2c_addr_match,
	output logic [7:0] ctrl_word_a,
	output logic [7:0] ctrl_word_b,
	output logic lp_control_enable,
	output logic forward_all,
	output logic forward_matched,
	output logic auto_ack,
	output logic parity_check_en,
	output logic control_sequence_crc_en,
	output logic [2:0] forward_gpio_lanes,
	output logic [3:0] lane_termination_en,
	output logic header_channel_filter_en,
	output logic i2c_forward
);
	localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);

	typedef struct packed {
		logic [7:0] lprx;
		logic [7:0] term;
		logic [7:0] hdr;
		logic [7:0] bcc;
		logic [7:0] fwd;
		logic [7:0] cap;
		logic [7:0] pid;
		logic [7:0] rdata;
		logic [15:0] step_cnt;
		logic [3:0] step_num;
		logic started;
		logic [1:0] pv_sync;
		logic pv_seen;
		logic [5:0] cap_s1;
		logic [5:0] cap_s2;
		logic [6:0] id_s1;
		logic [6:0] id_s2;
		logic [1:0] match_s;
		logic [1:0] i2c_s;
		slcr_ctrl_s ctrl;
		logic fwd_out;
		logic filt;
		logic [19:0] age_cyc;
	} slcr_state_s;

	slcr_state_s st;
	slcr_state_s next_st;

	function automatic logic [2:0] gpio_lanes(input logic [1:0] code);
		case (code)
			2'b00: gpio_lanes = 3'h0;
			2'b01: gpio_lanes = 3'h1;
			2'b10: gpio_lanes = 3'h2;
			default: gpio_lanes = 3'h4;
		endcase
	endfunction : gpio_lanes

	always_comb begin
		logic wr_cap;
		logic wr_pid;
		logic pv_rise;
		wr_cap = 1'b0;
		wr_pid = 1'b0;
		pv_rise = 1'b0;
		next_st = st;
		// link inputs cross into sys_clk through two flops
		next_st.pv_sync = {st.pv_sync[0], link_partner_valid};
		next_st.cap_s1 = link_partner_cap;
		next_st.cap_s2 = st.cap_s1;
		next_st.id_s1 = link_partner_id;
		next_st.id_s2 = st.id_s1;
		next_st.match_s = {st.match_s[0], hdr_match};
		next_st.i2c_s = {st.i2c_s[0], i2c_addr_match};
		pv_rise = st.pv_sync[1] && !st.pv_seen;
		next_st.pv_seen = st.pv_sync[1];
		if (reg_wr) begin
			case (reg_addr)
				SLCR_ADDR_LPRX: next_st.lprx = reg_wdata & SLCR_LPRX_WMASK; // R21
				SLCR_ADDR_TERM: next_st.term = reg_wdata; // R20
				SLCR_ADDR_HDR: next_st.hdr = reg_wdata;
				SLCR_ADDR_BCC: next_st.bcc = reg_wdata;
				SLCR_ADDR_FWD: next_st.fwd = reg_wdata;
				SLCR_ADDR_CAP: begin
					next_st.cap = reg_wdata;
					wr_cap = 1'b1;
				end
				SLCR_ADDR_PID: begin
					next_st.pid = reg_wdata;
					wr_pid = 1'b1;
				end
				default: ;
			endcase
		end
		// a software write in the same cycle wins over the link load
		if (pv_rise && !next_st.cap[SLCR_CAP_FRZ_BIT] && !wr_cap) begin
			next_st.cap[5:0] = st.cap_s2; // R12 R13 R15 R16 R17
		end
		if (pv_rise && !next_st.pid[SLCR_PID_FRZ_BIT] && !wr_pid) begin
			next_st.pid[7:1] = st.id_s2; // R18 R19
		end
		next_st.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				SLCR_ADDR_LPRX: next_st.rdata = st.lprx;
				SLCR_ADDR_TERM: next_st.rdata = st.term;
				SLCR_ADDR_HDR: next_st.rdata = st.hdr;
				SLCR_ADDR_BCC: next_st.rdata = st.bcc;
				SLCR_ADDR_FWD: next_st.rdata = st.fwd;
				SLCR_ADDR_CAP: next_st.rdata = st.cap;
				SLCR_ADDR_PID: next_st.rdata = st.pid;
				default: next_st.rdata = 8'h00;
			endcase
		end
		// start interval: (code+1) steps of 100 us counted from reset
		if (!st.started) begin
			if (st.step_cnt == STEP_LAST) begin
				next_st.step_cnt = 16'h0000;
				next_st.step_num = st.step_num + 4'h1;
				// a code lowered mid-count ends the wait at the next step
				if (st.step_num >= {1'b0, st.hdr[2:0]}) begin // R02
					next_st.started = 1'b1; // R01
				end
			end else begin
				next_st.step_cnt = st.step_cnt + 16'h0001;
			end
		end
		next_st.ctrl.header_channel_select = st.hdr[SLCR_HDR_SEL_LSB +: 2];
		next_st.ctrl.header_view_corrected = st.hdr[SLCR_HDR_CORR_BIT]; // R03
		next_st.ctrl.per_channel_header_capture_en = st.hdr[SLCR_HDR_VCI_BIT]; // R05
		next_st.ctrl.forward_all = st.bcc[SLCR_BCC_ALL_BIT]; // R06
		next_st.ctrl.forward_matched = st.bcc[SLCR_BCC_MATCH_BIT]; // R07
		next_st.ctrl.auto_ack = st.bcc[SLCR_BCC_ACK_BIT]; // R08
		next_st.ctrl.parity_check_en = st.bcc[SLCR_BCC_PAR_BIT]; // R09
		next_st.ctrl.control_sequence_crc_en = st.fwd[SLCR_FWD_CRC_BIT]; // R10
		next_st.ctrl.forward_gpio_lanes = gpio_lanes(st.fwd[1:0]); // R11
		next_st.ctrl.lane_termination_en = st.term[3:0]; // R20
		// forward decision: all, or on decode match
		next_st.fwd_out = st.bcc[SLCR_BCC_ALL_BIT]
			|| (st.bcc[SLCR_BCC_MATCH_BIT] && st.i2c_s[1]); // R06 R07
		// channel filter applies only with per-channel capture on
		next_st.filt = st.hdr[SLCR_HDR_VCI_BIT] && st.match_s[1]; // R04
		// saturating age since reset, read only by the start-interval checks
		if (st.age_cyc != 20'hfffff) begin
			next_st.age_cyc = st.age_cyc + 20'h00001;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.lprx <= SLCR_RST_LPRX;
			st.term <= SLCR_RST_TERM;
			st.hdr <= SLCR_RST_HDR;
			st.bcc <= SLCR_RST_BCC;
			st.fwd <= SLCR_RST_FWD;
			st.cap <= SLCR_RST_CAP;
			st.pid <= {SLCR_PID_DEFAULT, 1'b0};
			st.ctrl.header_view_corrected <= 1'b1;
			st.ctrl.parity_check_en <= 1'b1;
			st.ctrl.control_sequence_crc_en <= 1'b1; // R21
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign ctrl_word_a = st.cap;
	assign ctrl_word_b = st.pid;
	assign lp_control_enable = st.started;
	assign forward_all = st.ctrl.forward_all;
	assign forward_matched = st.ctrl.forward_matched;
	assign auto_ack = st.ctrl.auto_ack;
	assign parity_check_en = st.ctrl.parity_check_en;
	assign control_sequence_crc_en = st.ctrl.control_sequence_crc_en;
	assign forward_gpio_lanes = st.ctrl.forward_gpio_lanes;
	assign lane_termination_en = st.ctrl.lane_termination_en;
	assign header_channel_filter_en = st.filt;
	assign i2c_forward = st.fwd_out;

	property p_rdata_idle;
		@(posedge sys_clk) disable iff (!rst_b)
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle"); // R21

	property p_lp_gate;
		@(posedge sys_clk) disable iff (!rst_b)
		lp_control_enable |-> st.age_cyc >= 20'(STEP_CYC);
	endproperty
	a_lp_gate: assert property (p_lp_gate) else $error("lp control enabled early"); // R01

	property p_lp_stays;
		@(posedge sys_clk) disable iff (!rst_b)
		lp_control_enable |=> lp_control_enable;
	endproperty
	a_lp_stays: assert property (p_lp_stays) else $error("lp enable dropped"); // R01

	property p_gpio;
		@(posedge sys_clk) disable iff (!rst_b)
		st.fwd[1:0] == 2'b11 |=> forward_gpio_lanes == 3'h4;
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio count wrong"); // R11

	property p_cap_frozen;
		@(posedge sys_clk) disable iff (!rst_b)
		st.cap[SLCR_CAP_FRZ_BIT] && !(reg_wr && reg_addr == SLCR_ADDR_CAP) |=> $stable(st.cap);
	endproperty
	a_cap_frozen: assert property (p_cap_frozen) else $error("frozen cap changed"); // R12

	property p_pid_frozen;
		@(posedge sys_clk) disable iff (!rst_b)
		st.pid[SLCR_PID_FRZ_BIT] && !(reg_wr && reg_addr == SLCR_ADDR_PID) |=> $stable(st.pid);
	endproperty
	a_pid_frozen: assert property (p_pid_frozen) else $error("frozen id changed"); // R19

	property p_fwd_all;
		@(posedge sys_clk) disable iff (!rst_b)
		st.bcc[SLCR_BCC_ALL_BIT] |=> i2c_forward;
	endproperty
	a_fwd_all: assert property (p_fwd_all) else $error("forward-all ignored"); // R06

	property p_fwd_off;
		@(posedge sys_clk) disable iff (!rst_b)
		!st.bcc[SLCR_BCC_ALL_BIT] && !st.bcc[SLCR_BCC_MATCH_BIT] |=> !i2c_forward;
	endproperty
	a_fwd_off: assert property (p_fwd_off) else $error("forward while disabled"); // R07

	property p_filt;
		@(posedge sys_clk) disable iff (!rst_b)
		!st.hdr[SLCR_HDR_VCI_BIT] |=> !header_channel_filter_en;
	endproperty
	a_filt: assert property (p_filt) else $error("channel filter without enable"); // R04

	property p_lp_late;
		@(posedge sys_clk) disable iff (!rst_b)
		st.age_cyc >= 20'(8 * STEP_CYC) |-> lp_control_enable;
	endproperty
	a_lp_late: assert property (p_lp_late) else $error("lp control still blocked"); // R02

	property p_lp_rise;
		@(posedge sys_clk) disable iff (!rst_b)
		$rose(lp_control_enable)
			|-> st.age_cyc >= (20'($past(st.hdr[2:0])) + 20'h00001) * 20'(STEP_CYC);
	endproperty
	a_lp_rise: assert property (p_lp_rise) else $error("lp control before interval"); // R01

	property p_view;
		@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> st.ctrl.header_view_corrected == $past(st.hdr[SLCR_HDR_CORR_BIT]);
	endproperty
	a_view: assert property (p_view) else $error("header view select lost"); // R03

	property p_sel;
		@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> st.ctrl.header_channel_select == $past(st.hdr[SLCR_HDR_SEL_LSB +: 2]);
	endproperty
	a_sel: assert property (p_sel) else $error("channel select lost"); // R04

	property p_vci;
		@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> st.ctrl.per_channel_header_capture_en == $past(st.hdr[SLCR_HDR_VCI_BIT]);
	endproperty
	a_vci: assert property (p_vci) else $error("capture enable lost"); // R05

	property p_ack;
		@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> auto_ack == $past(st.bcc[SLCR_BCC_ACK_BIT]);
	endproperty
	a_ack: assert property (p_ack) else $error("auto ack wrong"); // R08

	property p_par;
		@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> parity_check_en == $past(st.bcc[SLCR_BCC_PAR_BIT]);
	endproperty
	a_par: assert property (p_par) else $error("parity enable wrong"); // R09

	property p_crc;
		@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> control_sequence_crc_en == $past(st.fwd[SLCR_FWD_CRC_BIT]);
	endproperty
	a_crc: assert property (p_crc) else $error("crc enable wrong"); // R10

	property p_gpio_none;
		@(posedge sys_clk) disable iff (!rst_b)
		st.fwd[1:0] == 2'b00 |=> forward_gpio_lanes == 3'h0;
	endproperty
	a_gpio_none: assert property (p_gpio_none) else $error("gpio count not zero"); // R11

	property p_gpio_one;
		@(posedge sys_clk) disable iff (!rst_b)
		st.fwd[1:0] == 2'b01 |=> forward_gpio_lanes == 3'h1;
	endproperty
	a_gpio_one: assert property (p_gpio_one) else $error("gpio count not one"); // R11

	property p_term;
		@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> lane_termination_en == $past(st.term[3:0]);
	endproperty
	a_term: assert property (p_term) else $error("termination enables wrong"); // R20

	property p_fwd_match;
		@(posedge sys_clk) disable iff (!rst_b)
		st.bcc[SLCR_BCC_MATCH_BIT] && st.i2c_s[1] |=> i2c_forward;
	endproperty
	a_fwd_match: assert property (p_fwd_match) else $error("matched forward ignored"); // R07

	property p_filt_on;
		@(posedge sys_clk) disable iff (!rst_b)
		st.hdr[SLCR_HDR_VCI_BIT] && st.match_s[1] |=> header_channel_filter_en;
	endproperty
	a_filt_on: assert property (p_filt_on) else $error("channel filter missing"); // R05

	property p_cap_load;
		@(posedge sys_clk) disable iff (!rst_b)
		st.pv_sync[1] && !st.pv_seen && !st.cap[SLCR_CAP_FRZ_BIT] && !reg_wr
			|=> st.cap[5:0] == $past(st.cap_s2);
	endproperty
	a_cap_load: assert property (p_cap_load) else $error("capabilities not loaded"); // R13

	property p_pid_load;
		@(posedge sys_clk) disable iff (!rst_b)
		st.pv_sync[1] && !st.pv_seen && !st.pid[SLCR_PID_FRZ_BIT] && !reg_wr
			|=> st.pid[7:1] == $past(st.id_s2);
	endproperty
	a_pid_load: assert property (p_pid_load) else $error("identifier not loaded"); // R18

	property p_cap_keep;
		@(posedge sys_clk) disable iff (!rst_b)
		!(st.pv_sync[1] && !st.pv_seen) && !reg_wr |=> $stable(st.cap);
	endproperty
	a_cap_keep: assert property (p_cap_keep) else $error("capabilities changed idle"); // R12

	property p_pid_keep;
		@(posedge sys_clk) disable iff (!rst_b)
		!(st.pv_sync[1] && !st.pv_seen) && !reg_wr |=> $stable(st.pid);
	endproperty
	a_pid_keep: assert property (p_pid_keep) else $error("identifier changed idle"); // R19

	property p_rd_bcc;
		@(posedge sys_clk) disable iff (!rst_b)
		reg_rd && reg_addr == SLCR_ADDR_BCC |=> reg_rdata == $past(st.bcc);
	endproperty
	a_rd_bcc: assert property (p_rd_bcc) else $error("read data wrong"); // R21
endmodule : slcr_regs
`default_nettype wire

// file: verification/slcr_partner_model.sv
// Purpose: remote deserializer stand-in driving partner capability and id
// Assumes: link_up from the bench marks back-channel detect
// Notes: valid rises LAG cycles after the values settle, never with them
`default_nettype none
module slcr_partner_model
	import slcr_pkg::*;
#(
	parameter int LAG = 3
) (
	input wire logic sys_clk,
	input wire logic link_up,
	input wire slcr_cap_s cap_in,
	input wire logic [6:0] id_in,
	output logic link_partner_valid,
	output logic [5:0] link_partner_cap,
	output logic [6:0] link_partner_id
);
	timeunit 1ns;
	timeprecision 100ps;
	int lag_cnt = 0;
	initial begin
		link_partner_valid = 1'b0;
		link_partner_cap = 6'h00;
		link_partner_id = 7'h00;
	end
	always @(posedge sys_clk) begin
		if (!link_up) begin
			// lines not held while down: show a moving pattern
			lag_cnt <= 0;
			link_partner_valid <= 1'b0;
			link_partner_cap <= ~link_partner_cap;
			link_partner_id <= ~link_partner_id;
		end else begin
			link_partner_cap <= cap_in;
			link_partner_id <= id_in;
			if (lag_cnt < LAG) begin
				lag_cnt <= lag_cnt + 1;
			end else begin
				link_partner_valid <= 1'b1;
			end
		end
	end
endmodule : slcr_partner_model
`default_nettype wire

// file: verification/tb_serializer_link_control_regs.sv
// Purpose: self-checking bench for the link control registers
// Assumes: STEP_CYC shortened to 4 so start intervals stay short
// Notes: each scenario resets the block where it needs clean state
`default_nettype none
module tb_serializer_link_control_regs
	import slcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int STEP = 4;
	localparam logic [7:0] ADDRS [7] = '{8'h23, 8'h24, 8'h31, 8'h32, 8'h33, 8'h35, 8'h37};
	localparam logic [7:0] RSTV [7] = '{8'h00, 8'h00, 8'h20, 8'h09, 8'h04, 8'h00, 8'h54};
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic hdr_match = 1'b0;
	logic i2c_addr_match = 1'b0;
	logic link_up = 1'b0;
	slcr_cap_s p_cap = '0;
	logic [6:0] p_id = 7'h00;
	logic [7:0] reg_rdata, ctrl_word_a, ctrl_word_b;
	logic link_partner_valid, lp_control_enable, forward_all, forward_matched, auto_ack;
	logic parity_check_en, control_sequence_crc_en, header_channel_filter_en, i2c_forward;
	logic [5:0] link_partner_cap;
	logic [6:0] link_partner_id;
	logic [2:0] forward_gpio_lanes;
	logic [3:0] lane_termination_en;
	int num_errors = 0;
	int checks = 0;

	slcr_regs #(.STEP_CYC(STEP)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.link_partner_valid(link_partner_valid), .link_partner_cap(link_partner_cap),
		.link_partner_id(link_partner_id), .hdr_match(hdr_match),
		.i2c_addr_match(i2c_addr_match), .ctrl_word_a(ctrl_word_a), .ctrl_word_b(ctrl_word_b),
		.lp_control_enable(lp_control_enable), .forward_all(forward_all),
		.forward_matched(forward_matched), .auto_ack(auto_ack),
		.parity_check_en(parity_check_en), .control_sequence_crc_en(control_sequence_crc_en),
		.forward_gpio_lanes(forward_gpio_lanes), .lane_termination_en(lane_termination_en),
		.header_channel_filter_en(header_channel_filter_en), .i2c_forward(i2c_forward));
	slcr_partner_model #(.LAG(3)) partner (.sys_clk(sys_clk), .link_up(link_up),
		.cap_in(p_cap), .id_in(p_id), .link_partner_valid(link_partner_valid),
		.link_partner_cap(link_partner_cap), .link_partner_id(link_partner_id));

	always #5 sys_clk = ~sys_clk;

	task automatic test_done;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset;
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
	endtask : do_reset

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd

	// sync flops plus output register
	task automatic settle;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic t_defaults;
		chk({6'h00, parity_check_en, control_sequence_crc_en}, 8'h03);
		rd(8'h30, 8'h00);
		for (int i = 0; i < 7; i++) rd(ADDRS[i], RSTV[i]);
		@(posedge sys_clk);
		#1;
		chk(reg_rdata, 8'h00);
	endtask : t_defaults

	task automatic t_interval(input logic [2:0] code);
		int n;
		int lo;
		do_reset();
		wr(8'h31, {5'b00100, code});
		n = 2;
		lo = (code + 1) * STEP;
		while (lp_control_enable !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= 100) begin
			num_errors++;
			$display("[FAIL] %0t start interval never ended", $time);
			test_done();
		end
		chk(8'(n >= lo && n <= lo + 4), 8'h01);
	endtask : t_interval

	task automatic t_rw;
		logic [7:0] pat;
		for (int p = 0; p < 2; p++) begin
			pat = p ? 8'h00 : 8'hff;
			for (int i = 0; i < 7; i++) wr(ADDRS[i], pat);
			wr(8'h30, 8'hff);
			for (int i = 0; i < 7; i++) rd(ADDRS[i], i ? pat : pat & 8'h7f);
			rd(8'h30, 8'h00);
		end
	endtask : t_rw

	task automatic t_ctrl;
		logic [2:0] gpio [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
		wr(8'h32, 8'he0);
		settle();
		chk({4'h0, forward_all, forward_matched, auto_ack, parity_check_en}, 8'h0e);
		for (int c = 0; c < 4; c++) begin
			wr(8'h33, {5'h00, c[0], c[1:0]});
			settle();
			chk({4'h0, control_sequence_crc_en, forward_gpio_lanes}, {4'h0, c[0], gpio[c]});
		end
		wr(8'h24, 8'ha5);
		settle();
		chk({4'h0, lane_termination_en}, 8'h05);
		for (int k = 0; k < 8; k++) begin
			@(posedge sys_clk);
			i2c_addr_match <= k[0];
			wr(8'h32, {k[2], k[1], 6'h09});
			settle();
			chk({7'h00, i2c_forward}, 8'(k[2] | (k[1] & k[0])));
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			hdr_match <= k[0];
			wr(8'h31, {2'b01, 1'b1, k[1], 4'h0});
			settle();
			chk({7'h00, header_channel_filter_en}, 8'(k[1] & k[0]));
		end
	endtask : t_ctrl

	task automatic link_cycle(input logic [5:0] c, input logic [6:0] id);
		int n;
		@(posedge sys_clk);
		p_cap <= c;
		p_id <= id;
		link_up <= 1'b1;
		n = 0;
		while (link_partner_valid !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 20) begin
			num_errors++;
			$display("[FAIL] %0t partner link never came up", $time);
			test_done();
		end
		settle();
	endtask : link_cycle

	task automatic t_link;
		do_reset();
		link_cycle(6'h35, 7'h11);
		rd(8'h35, 8'h35);
		rd(8'h37, 8'h22);
		chk(ctrl_word_a, 8'h35);
		chk(ctrl_word_b, 8'h22);
		@(posedge sys_clk);
		link_up <= 1'b0;
		wr(8'h35, 8'h8a);
		wr(8'h37, 8'h45);
		link_cycle(6'h10, 7'h7e);
		rd(8'h35, 8'h8a);
		rd(8'h37, 8'h45);
	endtask : t_link

	initial begin
		do_reset();
		t_defaults();
		t_rw();
		t_ctrl();
		t_interval(3'd0);
		t_interval(3'd3);
		t_interval(3'd7);
		t_link();
		test_done();
	end
endmodule : tb_serializer_link_control_regs
`default_nettype wire
